//--- core/sup_consts.svh
`ifndef SUP_CONSTS_SVH
`define SUP_CONSTS_SVH

// Clock rate of clk_i
`define SUP_CLK_HZ          50000000
`define SUP_CYC_PER_MS      (`SUP_CLK_HZ / 1000)

// Reset stretch after supply recovery, standard and long-pulse builds
`define SUP_STRETCH_MS      50
`define SUP_STRETCH_LONG_MS 200

// Internal watchdog timeouts, selected by the timebase strap
`define SUP_WD_LONG_MS      1600
`define SUP_WD_SHORT_MS     100

// External timebase: rising edges of timebase_pin per watchdog timeout
`define SUP_EXT_TICKS       1024

// Width of the timing counters (holds 1.6 s of clk_i)
`define SUP_CNT_W           27

// Reset value of the one-hot state
`define SUP_ST_RESET        4'h1

`endif

//--- core/sup_pkg.sv
`include "sup_consts.svh"

package sup_pkg;

  typedef enum logic [3:0] {
    SUP_OFF     = 4'h1,
    SUP_STRETCH = 4'h2,
    SUP_RUN     = 4'h4,
    SUP_WDRST   = 4'h8
  } sup_state_t;

  // Pin inputs, all asynchronous to clk_i
  typedef struct packed {
    logic supply_low;        // Main supply below reset threshold
    logic main_below_backup; // Main supply below backup_supply
    logic power_fail_sense_in; // High while sense input above reference
    logic watchdog_kick_in;
    logic watchdog_float;    // High while kick input floats
    logic timebase_select;
    logic timebase_pin;
    logic ce_in_n;
  } sup_pins_t;

  typedef struct packed {
    logic reset_n;
    logic reset;
    logic ce_out_n;
    logic power_fail_warn_n;
    logic backup_status_out;
    logic watchdog_out_n;
  } sup_outs_t;

  typedef struct packed {
    sup_pins_t               s1;
    sup_pins_t               s2;
    logic                    kick_prev;
    logic                    tb_prev;
    sup_state_t              st;
    logic [`SUP_CNT_W-1:0]   cnt;
    logic [`SUP_CNT_W-1:0]   wd_cnt;
    sup_outs_t               o;
  } sup_regs_t;

endpackage

//--- core/sup_gate.sv
`timescale 1ns/1ns
`include "sup_consts.svh"

module sup_gate #(
  parameter int unsigned STRETCH_CYC = `SUP_CYC_PER_MS * `SUP_STRETCH_MS,
  parameter int unsigned WD_LONG_CYC = `SUP_CYC_PER_MS * `SUP_WD_LONG_MS,
  parameter int unsigned WD_SHORT_CYC = `SUP_CYC_PER_MS * `SUP_WD_SHORT_MS,
  parameter int unsigned EXT_TICKS   = `SUP_EXT_TICKS
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  // Comparator and pin inputs
  input  wire sup_pkg::sup_pins_t pins_i,
  // Supervisory outputs
  output sup_pkg::sup_outs_t      outs_o
);
  import sup_pkg::*;

  localparam logic [`SUP_CNT_W-1:0] STRETCH_M1 =
    `SUP_CNT_W'(STRETCH_CYC - 1);

  sup_regs_t             q;
  sup_regs_t             next_q;
  logic                  down;
  logic                  kick_edge;
  logic                  tick;
  logic                  wd_on;
  logic [`SUP_CNT_W-1:0] wd_lim;

  // Last count of the selected watchdog period
  function automatic logic [`SUP_CNT_W-1:0] wd_last(input logic sel,
                                                    input logic strap);
    logic [`SUP_CNT_W-1:0] r;
    if (!sel)
      r = `SUP_CNT_W'(EXT_TICKS - 1);
    else if (strap)
      r = `SUP_CNT_W'(WD_LONG_CYC - 1);
    else
      r = `SUP_CNT_W'(WD_SHORT_CYC - 1);
    return r;
  endfunction

  assign down      = q.s2.supply_low | q.s2.main_below_backup;
  assign kick_edge = q.s2.watchdog_kick_in ^ q.kick_prev;
  assign tick      = q.s2.timebase_select |
                     (q.s2.timebase_pin & ~q.tb_prev);
  assign wd_lim    = wd_last(q.s2.timebase_select, q.s2.timebase_pin);
  assign wd_on     = ~q.s2.watchdog_float & ~down;

  always_comb begin
    next_q           = q;
    next_q.s1        = pins_i;
    next_q.s2        = q.s1;
    next_q.kick_prev = q.s2.watchdog_kick_in;
    next_q.tb_prev   = q.s2.timebase_pin;

    case (q.st)
      SUP_OFF: begin
        next_q.cnt = '0;
        if (!down) begin
          next_q.st = SUP_STRETCH;
        end
      end
      SUP_STRETCH, SUP_WDRST: begin
        if (q.cnt == STRETCH_M1) begin
          next_q.st     = SUP_RUN;
          next_q.cnt    = '0;
          next_q.wd_cnt = '0;
        end else begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end
      SUP_RUN: begin
        if (!wd_on || kick_edge) begin
          next_q.wd_cnt = '0;
        end else if (tick) begin
          if (q.wd_cnt >= wd_lim) begin
            next_q.st       = SUP_WDRST;
            next_q.cnt      = '0;
            next_q.wd_cnt   = '0;
            next_q.o.watchdog_out_n = 1'b0;
          end else begin
            next_q.wd_cnt = q.wd_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_q.st = SUP_OFF;
      end
    endcase

    // Watchdog is held clear outside normal running
    if (q.st != SUP_RUN) begin
      next_q.wd_cnt = '0;
    end
    if (kick_edge && wd_on) begin
      next_q.o.watchdog_out_n = 1'b1;
    end
    if (down) begin
      next_q.st               = SUP_OFF;
      next_q.cnt              = '0;
      next_q.o.watchdog_out_n = 1'b1;
    end

    next_q.o.reset_n = (next_q.st == SUP_RUN);
    next_q.o.reset   = ~(next_q.st == SUP_RUN);
    next_q.o.ce_out_n = down ? 1'b1 : q.s2.ce_in_n;
    next_q.o.power_fail_warn_n = q.s2.main_below_backup ? 1'b0 :
                                 q.s2.power_fail_sense_in;
    next_q.o.backup_status_out = q.s2.main_below_backup;
  end

  // Reset forces every output to its safe level, not only the state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q      <= '0;
      q.st   <= sup_state_t'(`SUP_ST_RESET);
      q.o.reset    <= 1'b1;
      q.o.ce_out_n <= 1'b1;
      q.o.power_fail_warn_n <= 1'b1;
      q.o.watchdog_out_n    <= 1'b1;
      q.s1.ce_in_n <= 1'b1;
      q.s2.ce_in_n <= 1'b1;
      // Sync stages start at supply low and sense high, so the first
      // cycles after reset show neither a false warning nor a release
      q.s1.supply_low <= 1'b1;
      q.s2.supply_low <= 1'b1;
      q.s1.power_fail_sense_in <= 1'b1;
      q.s2.power_fail_sense_in <= 1'b1;
    end else if (clk_en_i) begin
      q <= next_q;
    end
  end

  assign outs_o = q.o;

  AST_RESET_LOW: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    q.s2.supply_low |=> !outs_o.reset_n)
    else $error("reset_n high while supply low");

  AST_STRETCH_DONE: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    $rose(outs_o.reset_n) |-> $past(q.cnt) == STRETCH_M1)
    else $error("reset released before stretch ended");

  AST_WD_PULSE: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (q.st == SUP_RUN && wd_on && !kick_edge && tick &&
     q.wd_cnt >= wd_lim)
    |=> q.st == SUP_WDRST && !outs_o.reset_n && !outs_o.watchdog_out_n)
    else $error("watchdog timeout gave no reset pulse");

  AST_WD_RESTART: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (q.st == SUP_WDRST && q.cnt == STRETCH_M1 && !down)
    |=> q.st == SUP_RUN && q.wd_cnt == '0 && outs_o.reset_n)
    else $error("watchdog count not restarted after pulse");

  AST_WD_FLOAT: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    q.s2.watchdog_float && q.st != SUP_WDRST
    |=> q.wd_cnt == '0 && q.st != SUP_WDRST)
    else $error("watchdog ran while kick input floats");

  AST_EXT_HOLD: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (q.st == SUP_RUN && wd_on && !tick && !kick_edge)
    |=> q.wd_cnt == $past(q.wd_cnt))
    else $error("watchdog counted without a tick");

  AST_CE_PASS: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    !down |=> outs_o.ce_out_n == $past(q.s2.ce_in_n))
    else $error("chip enable not passed through");

  AST_CE_BLOCK: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    (q.s2.supply_low || q.s2.main_below_backup) |=> outs_o.ce_out_n)
    else $error("chip enable not blocked");

  AST_PF_WARN: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    !q.s2.main_below_backup
    |=> outs_o.power_fail_warn_n == $past(q.s2.power_fail_sense_in))
    else $error("power-fail warning wrong level");

  AST_RESET_PAIR: assert property (@(posedge clk_i)
    disable iff (reset_i)
    outs_o.reset == !outs_o.reset_n)
    else $error("reset outputs not complementary");

  AST_BACKUP: assert property (@(posedge clk_i)
    disable iff (reset_i || !clk_en_i)
    1'b1 |=> outs_o.backup_status_out == $past(q.s2.main_below_backup))
    else $error("backup status wrong");

endmodule

//--- dv/sup_host.sv
`timescale 1ns/1ns
module sup_host (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic run_i,
  // Kick line
  output logic      kick_o
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    kick_o = 1'b0;
  end
  always @(posedge clk_i) begin
    cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
    if (run_i && cnt == 4'h9) begin
      kick_o <= ~kick_o;
    end
  end
endmodule

//--- dv/tb_sup_gate.sv
`timescale 1ns/1ns
module tb_sup_gate;
  import sup_pkg::*;
  localparam int STR = 20;
  localparam int WDL = 100;
  localparam int WDS = 40;
  localparam int EXT = 8;
  localparam int SL = 7, MB = 6, PF = 5, FL = 3, SEL = 2, TB = 1, CE = 0;
  logic      clk_i;
  logic      reset_i;
  logic      run;
  logic      tb_run;
  logic      en;
  logic      kick;
  sup_pins_t pins;
  sup_pins_t pins_dut;
  sup_outs_t outs;
  int        num_errors;
  int        num_checks;
  int        cyc;
  int        n;

  sup_gate #(.STRETCH_CYC(STR), .WD_LONG_CYC(WDL), .WD_SHORT_CYC(WDS),
    .EXT_TICKS(EXT)) i_sup_gate (.clk_i(clk_i), .reset_i(reset_i),
    .clk_en_i(en), .pins_i(pins_dut), .outs_o(outs));
  sup_host i_sup_host (.clk_i(clk_i), .run_i(run), .kick_o(kick));

  always_comb begin
    pins_dut = pins;
    pins_dut.watchdog_kick_in = kick;
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Toggling every edge gives one timebase rise per two cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (tb_run) begin
      pins[TB] <= ~pins[TB];
    end
    if (cyc == 8000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic drv(input int f, input logic v);
    @(posedge clk_i);
    pins[f] <= v;
  endtask
  // Cycles until reset_n (w=0) or watchdog_out_n (w=1) reaches lvl
  task automatic until_lvl(input int w, input logic lvl, output int c);
    c = 0;
    while ((w ? outs.watchdog_out_n : outs.reset_n) !== lvl && c < 2000) begin
      wt(1);
      c++;
    end
  endtask
  // Host stops kicking; the last kick was up to 10 cycles earlier
  task automatic stall(input int lim);
    @(posedge clk_i);
    run <= 1'b0;
    until_lvl(1, 1'b0, n);
    chk(n >= lim - 12 && n <= lim + 6, 1'b1, "timeout period");
  endtask
  task automatic resume();
    @(posedge clk_i);
    run <= 1'b1;
    until_lvl(0, 1'b1, n);
    wt(25);
    chk(outs.watchdog_out_n, 1'b1, "kick clears watchdog flag");
  endtask

  task automatic t_power();
    drv(CE, 1'b0);
    wt(5);
    chk(outs.reset_n, 1'b0, "reset_n low supply");
    chk(outs.reset, 1'b1, "reset inverse");
    chk(outs.ce_out_n, 1'b1, "ce forced high");
    drv(SL, 1'b0);
    until_lvl(0, 1'b1, n);
    chk(n >= STR && n <= STR + 6, 1'b1, "stretch length");
    chk(outs.reset, 1'b0, "reset inverse released");
    wt(5);
    chk(outs.ce_out_n, 1'b0, "ce follows low");
    drv(CE, 1'b1);
    wt(5);
    chk(outs.ce_out_n, 1'b1, "ce follows high");
    // Clock enable low must freeze the gate output
    @(posedge clk_i);
    en <= 1'b0;
    drv(CE, 1'b0);
    wt(5);
    chk(outs.ce_out_n, 1'b1, "ce frozen while disabled");
    @(posedge clk_i);
    en <= 1'b1;
    wt(5);
    chk(outs.ce_out_n, 1'b0, "ce follows after enable");
    drv(CE, 1'b1);
    $display("test power done");
  endtask
  task automatic t_aux();
    drv(PF, 1'b0);
    wt(5);
    chk(outs.power_fail_warn_n, 1'b0, "warn low");
    drv(PF, 1'b1);
    drv(CE, 1'b0);
    drv(MB, 1'b1);
    wt(5);
    chk(outs.backup_status_out, 1'b1, "backup status");
    chk(outs.ce_out_n, 1'b1, "ce held in backup");
    drv(MB, 1'b0);
    wt(5);
    chk(outs.backup_status_out, 1'b0, "backup status off");
    chk(outs.power_fail_warn_n, 1'b1, "warn released");
    drv(CE, 1'b1);
    until_lvl(0, 1'b1, n);
    $display("test aux done");
  endtask
  task automatic t_wdog();
    wt(300);
    chk(outs.reset_n, 1'b1, "kicked host runs");
    stall(WDL);
    chk(outs.reset_n, 1'b0, "watchdog reset");
    until_lvl(0, 1'b1, n);
    chk(n >= STR - 1 && n <= STR + 2, 1'b1, "pulse length");
    until_lvl(0, 1'b0, n);
    chk(n >= WDL - 2 && n <= WDL + 4, 1'b1, "repeat period");
    resume();
    drv(TB, 1'b0);
    stall(WDS);
    resume();
    $display("test watchdog done");
  endtask
  task automatic t_ext();
    drv(SEL, 1'b0);
    run <= 1'b0;
    wt(200);
    chk(outs.watchdog_out_n, 1'b1, "no ticks no timeout");
    resume();
    @(posedge clk_i);
    tb_run <= 1'b1;
    stall(2 * EXT);
    resume();
    // Timebase keeps ticking so only the float can hold the watchdog off
    drv(FL, 1'b1);
    run <= 1'b0;
    wt(300);
    chk(outs.watchdog_out_n, 1'b1, "float no flag");
    chk(outs.reset_n, 1'b1, "float no reset");
    drv(FL, 1'b0);
    run <= 1'b1;
    tb_run <= 1'b0;
    $display("test external and float done");
  endtask

  initial begin
    pins = 8'ha7;
    reset_i = 1'b1;
    run = 1'b0;
    tb_run = 1'b0;
    en = 1'b1;
    cyc = 0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    run <= 1'b1;
    wt(1);
    chk(outs.reset_n, 1'b0, "reset_n after reset");
    chk(outs.power_fail_warn_n, 1'b1, "no warning after reset");
    t_power();
    t_aux();
    t_wdog();
    t_ext();
    complete_run();
  end
endmodule
